// File: src/crm_pkg.sv
// Shared constants of the configuration register map
package crm_pkg;

	// Host side port keys and offsets
	localparam logic [7:0]  KEY_ENTER       = 8'h55;
	localparam logic [7:0]  KEY_EXIT        = 8'hAA;
	localparam logic [15:0] DATA_PORT_STEP  = 16'h0001;

	// Global register indices
	localparam logic [7:0]  IDX_CHIP_CTRL   = 8'h02;
	localparam logic [7:0]  IDX_RSVD_A      = 8'h03;
	localparam logic [7:0]  IDX_LDN         = 8'h07;
	localparam logic [7:0]  IDX_PART_ID     = 8'h20;
	localparam logic [7:0]  IDX_SI_REV      = 8'h21;
	localparam logic [7:0]  IDX_BASE_LOW    = 8'h26;
	localparam logic [7:0]  IDX_BASE_HIGH   = 8'h27;
	localparam logic [7:0]  IDX_FIRST_DEV   = 8'h30;

	// Field position of the soft reset request
	localparam int          SOFT_RST_BIT    = 0;

	// Strapped values of the port base low byte
	localparam logic [7:0]  BASE_LOW_STRAP0 = 8'h2E;
	localparam logic [7:0]  BASE_LOW_STRAP1 = 8'h4E;

	// Access block after main power-on, in ns and in cycles
	localparam int          POR_BLOCK_NS    = 500000;
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          POR_BLOCK_CYC   = (POR_BLOCK_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// Cycles for the strap synchroniser to settle after power-up
	localparam logic [1:0]  STRAP_SETTLE    = 2'h3;

	// Which reset sources load a register
	typedef enum logic [1:0] {
		CLS_ALL       = 2'h0,	// Bus, main, standby and soft
		CLS_HW        = 2'h1,	// Bus, main and standby
		CLS_BUS_MAIN  = 2'h2,	// Bus and main only
		CLS_MAIN_STBY = 2'h3	// Main and standby only
	} crm_class_type;

	// Marker for a register that belongs to no logical device
	localparam logic [7:0]  LD_GLOBAL       = 8'hFF;

	// Storage table: one entry per held register
	localparam int          NUM_REGS        = 30;
	localparam int          SLOT_BASE_LOW   = 4;
	localparam int          SLOT_BASE_HIGH  = 5;
	localparam logic [7:0] REG_INDEX [NUM_REGS] = '{
		8'h07, 8'h22, 8'h23, 8'h24, 8'h26, 8'h27, 8'h2A, 8'h2B, 8'h2C, 8'h2D,
		8'h2E, 8'h2F, 8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hF0, 8'hF1, 8'hF2,
		8'hF4, 8'hF5, 8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hF0, 8'hF1, 8'h30};
	localparam logic [7:0] REG_LD [NUM_REGS] = '{
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h04};
	localparam logic [7:0] REG_RST [NUM_REGS] = '{
		8'h00, 8'h00, 8'h00, 8'h44, 8'h2E, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h03, 8'hF0, 8'h06, 8'h02, 8'h0E, 8'h00, 8'hFF,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h3C, 8'h00, 8'h00};
	localparam crm_class_type REG_CLS [NUM_REGS] = '{
		CLS_ALL, CLS_ALL, CLS_HW, CLS_HW, CLS_BUS_MAIN, CLS_BUS_MAIN,
		CLS_MAIN_STBY, CLS_MAIN_STBY, CLS_MAIN_STBY, CLS_MAIN_STBY,
		CLS_MAIN_STBY, CLS_MAIN_STBY, CLS_ALL, CLS_ALL, CLS_ALL, CLS_ALL,
		CLS_ALL, CLS_HW, CLS_HW, CLS_HW, CLS_HW, CLS_HW, CLS_ALL, CLS_ALL,
		CLS_ALL, CLS_ALL, CLS_ALL, CLS_HW, CLS_HW, CLS_ALL};

endpackage

// File: src/crm_cfg_cell.sv
`timescale 1ns/1ns
`default_nettype none
// One configuration byte with its per-source reset behaviour
module crm_cfg_cell #(
	parameter logic [7:0]             RST_VAL = 8'h00,
	parameter crm_pkg::crm_class_type CLS     = crm_pkg::CLS_ALL
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       bus_rst,
	input  wire logic       main_por,
	input  wire logic       stby_por,
	input  wire logic       soft_rst,
	input  wire logic       ext_load,
	input  wire logic [7:0] load_val,
	input  wire logic       wr_en,
	input  wire logic [7:0] wdata,
	output logic      [7:0] q
);

	logic [7:0] q_reg;	// Stored byte
	logic [7:0] q_next;	// Next stored byte
	logic       rst_hit;	// A reset source that this class obeys

	// Reset sources filtered by class; soft reset only for CLS_ALL
	assign rst_hit = main_por
		| (bus_rst & (CLS != crm_pkg::CLS_MAIN_STBY))
		| (stby_por & (CLS != crm_pkg::CLS_BUS_MAIN))
		| (soft_rst & (CLS == crm_pkg::CLS_ALL));

	// Reset events win over a host write in the same cycle
	assign q_next = (rst_hit | ext_load) ? load_val
		: (wr_en ? wdata : q_reg);

	// Byte storage
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			q_reg <= RST_VAL;
		else
			q_reg <= q_next;
	end

	assign q = q_reg;

endmodule
`default_nettype wire

// File: src/crm_por_gate.sv
`timescale 1ns/1ns
`default_nettype none
// Blocks host access for a fixed time after main power-on
module crm_por_gate #(
	parameter int CYCLES = crm_pkg::POR_BLOCK_CYC
) (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic start,
	output logic      busy
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt_reg;	// Cycles left in the block
	logic [CW-1:0] cnt_next;	// Next count

	// Restart on every main power-on, else count down to zero
	assign cnt_next = start ? CW'(CYCLES)
		: ((cnt_reg != '0) ? cnt_reg - CW'(1) : cnt_reg);

	// Down counter
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	assign busy = (cnt_reg != '0);

endmodule
`default_nettype wire

// File: src/crm_config_map.sv
// Notes on behaviour
// - bit 0 write at 0x02 starts soft reset
// - host accesses refused 500 us after main POR
// - 0x26 loads strapped 0x2E/0x4E on bus/main reset
// - 0x27 loads zero on bus/main reset only
// - 0x20 returns fixed part identification byte
// - 0x21 returns fixed silicon revision byte
// - reserved 0x03 is read-only, reads zero
// - data written at 07h selects current device
// - data port write hits indexed register of device
// - floppy base/irq/dma defaults load on every reset
// - printer modes hardware-reset only, dma on all
// - key 0x55 enables index and data ports
// - key 0xAA returns to run mode
// - index at base address, data at base plus one
// - port accesses ignored outside configuration mode
`timescale 1ns/1ns
`default_nettype none
module crm_config_map #(
	parameter logic [7:0] PART_ID       = 8'hA5,	// Arbitrary value
	parameter logic [7:0] SILICON_REV   = 8'h01,	// Arbitrary value
	parameter int         POR_BLOCK_CYC = crm_pkg::POR_BLOCK_CYC
) (
	input  wire logic                         ref_clk,
	input  wire logic                         nrst,
	input  wire logic                         bus_rst,
	input  wire logic                         main_por,
	input  wire logic                         stby_por,
	input  wire logic                         strap_pin,
	input  wire logic [15:0]                  io_addr,
	input  wire logic [7:0]                   io_wdata,
	input  wire logic                         io_wr,
	input  wire logic                         io_rd,
	output logic      [7:0]                   io_rdata,
	output logic                              io_rvalid,
	output logic                              cfg_mode,
	output logic                              host_blocked,
	output logic                              soft_rst_pulse,
	output logic      [7:0]                   logical_device_select,
	output logic      [15:0]                  config_port_base,
	output logic      [crm_pkg::NUM_REGS*8-1:0] cfg_regs
);

	// Run and configuration states
	// One-hot codes; any other code falls back to run mode
	typedef enum logic [1:0] {
		ST_RUN    = 2'b01,	// Index and data ports dead
		ST_CONFIG = 2'b10	// Index and data ports live
	} crm_state_type;

	// Registers of the block and their next values
	crm_state_type state_reg;	// Current mode
	crm_state_type state_next;	// Next mode
	logic [7:0]    index_reg;	// Index port contents
	logic [7:0]    index_next;	// Next index
	logic          soft_reg;	// Soft reset pulse, one cycle
	logic          soft_next;	// Next soft reset pulse
	logic [7:0]    rdata_reg;	// Read answer byte
	logic [7:0]    rdata_next;	// Next read answer
	logic          rvalid_reg;	// Read answer strobe
	logic          rvalid_next;	// Next read answer strobe
	logic          strap_meta_reg;	// Strap synchroniser, first stage
	logic          strap_sync_reg;	// Strap synchroniser, second stage
	logic [1:0]    settle_reg;	// Settle counter after power-up
	logic [1:0]    settle_next;	// Next settle count
	logic          strap_load;	// Power-up strap capture pulse
	logic          hw_rst;	// Any hardware reset source
	logic          blocked;	// Main power-on access block
	logic [7:0]    strap_val;	// Base low byte chosen by strap

	// Host decode wires
	// Plain decode of the current host inputs
	logic          hit_index;	// Address equals port base
	logic          hit_data;	// Address equals port base plus one
	logic          live;	// Host cycles may be taken
	logic          wr_index;	// Index port write
	logic          wr_data;	// Data port write
	logic          rd_index;	// Index port read
	logic          rd_data;	// Data port read
	logic          key_enter;	// Entry key seen in run mode
	logic          key_exit;	// Exit key seen in config mode
	logic          idx_global;	// Index lies in the global range

	// Storage and read path
	// Slot order follows the package table
	logic [7:0]    reg_q     [crm_pkg::NUM_REGS];	// Stored bytes
	logic [7:0]    rd_chain  [crm_pkg::NUM_REGS+1];	// OR chain
	logic [7:0]    fixed_rd;	// Hard wired global bytes
	logic [7:0]    rd_mux;	// Byte answered on a data read

	// Synchronous reset events from the system side
	// Each one forces run mode and clears the index port
	// Cells pick the events that reload them by class
	// The asynchronous nrst only brings the flops up at power-up
	assign hw_rst = bus_rst | main_por | stby_por;

	// Strap pin is asynchronous: two flops before use
	// Only the second stage is read, so a late pin edge
	// never reaches the base decode half settled
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			strap_meta_reg <= 1'b0;
			strap_sync_reg <= 1'b0;
		end
		else
		begin
			strap_meta_reg <= strap_pin;
			strap_sync_reg <= strap_meta_reg;
		end
	end

	// Strap choice for the port base low byte
	// Used at power-up and on every bus or main reset
	assign strap_val = strap_sync_reg ? crm_pkg::BASE_LOW_STRAP1
		: crm_pkg::BASE_LOW_STRAP0;

	// Counts cycles after power-up until the strap has settled
	// The base low byte first holds its fixed reset value,
	// then takes the strap choice once the synchroniser is full
	assign settle_next = (settle_reg == crm_pkg::STRAP_SETTLE) ? settle_reg
		: settle_reg + 2'h1;
	assign strap_load = (settle_reg == (crm_pkg::STRAP_SETTLE - 2'h1));

	// Settle counter
	// Saturates, so the strap capture happens once per power-up
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			settle_reg <= 2'h0;
		else
			settle_reg <= settle_next;
	end

	// Access block after main power-on
	// Host cycles are dropped, not delayed, while it runs;
	// a host that talks too early gets no answer at all
	// A repeated main power-on restarts the full interval
	// The count lives in a small down counter
	crm_por_gate #(
		.CYCLES (POR_BLOCK_CYC)
	) u_por_gate (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.start   (main_por),
		.busy    (blocked)
	);

	// Port decode against the relocatable base
	// A new base is used from the cycle after its data write,
	// so the host must move to the new address at once
	// Base plus one wraps at the top of the address space
	assign config_port_base = {reg_q[crm_pkg::SLOT_BASE_HIGH],
		reg_q[crm_pkg::SLOT_BASE_LOW]};
	assign hit_index = (io_addr == config_port_base);
	assign hit_data  = (io_addr == (config_port_base
		+ crm_pkg::DATA_PORT_STEP));
	// No host cycle lands during the block or a reset event
	assign live      = !blocked & !hw_rst;

	// Index and data ports only work in configuration mode
	// The exit key is kept out of the index register,
	// so leaving the mode by the exit key never disturbs the stored index
	// A read at the index port returns the stored index
	assign wr_index  = live & io_wr & hit_index & (state_reg == ST_CONFIG)
		& (io_wdata != crm_pkg::KEY_EXIT);
	assign wr_data   = live & io_wr & hit_data
		& (state_reg == ST_CONFIG);
	assign rd_index  = live & io_rd & hit_index
		& (state_reg == ST_CONFIG);
	assign rd_data   = live & io_rd & hit_data
		& (state_reg == ST_CONFIG);

	// Key detection on the config port
	// Entry only from run mode, exit only from config mode
	// The entry key written in config mode becomes an index
	// Keys are written only, never read back
	assign key_enter = live & io_wr & hit_index & (state_reg == ST_RUN)
		& (io_wdata == crm_pkg::KEY_ENTER);
	assign key_exit  = live & io_wr & hit_index & (state_reg == ST_CONFIG)
		& (io_wdata == crm_pkg::KEY_EXIT);

	// Mode change
	// Two modes only; run mode always waits for the entry key
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN:
			begin
				// Wait for the entry key
				if (key_enter)
					state_next = ST_CONFIG;
			end
			ST_CONFIG:
			begin
				// Wait for the exit key
				if (key_exit)
					state_next = ST_RUN;
			end
			default:
				state_next = ST_RUN;
		endcase
		// Reset events override the keys
		if (hw_rst)
			state_next = ST_RUN;
	end

	// Index port holds the host's last index
	// Cleared by every system reset event, not by soft reset
	assign index_next = hw_rst ? 8'h00
		: (wr_index ? io_wdata : index_reg);

	// Soft reset request, cleared again after one cycle
	// Only bit 0 of a data write at chip control counts;
	// the byte is never stored, so reads of it give zero
	// The cells see the pulse one cycle after the host write
	assign soft_next = wr_data & (index_reg == crm_pkg::IDX_CHIP_CTRL)
		& io_wdata[crm_pkg::SOFT_RST_BIT];

	// Mode, index and soft reset flops
	// Power-up leaves run mode, index zero, no pending request
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= ST_RUN;
			index_reg <= 8'h00;
			soft_reg  <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			index_reg <= index_next;
			soft_reg  <= soft_next;
		end
	end

	// Global range covers indices below the first device register
	// Indices from there up go to the selected logical device
	assign idx_global = (index_reg < crm_pkg::IDX_FIRST_DEV);

	// One cell per held register, with its reset class
	// Each slot matches one index, and one device unless global
	// At most one slot matches, so the read OR chain
	// never merges two bytes
	// The base low slot reloads the strap choice, not a constant
	genvar gi;
	generate
		for (gi = 0; gi < crm_pkg::NUM_REGS; gi++)
		begin : g_reg
			logic       sel;	// Index and device match this slot
			logic       rst_low;	// Slot is the port base low byte
			logic [7:0] load;	// Value loaded on a reset event

			assign rst_low = (gi == crm_pkg::SLOT_BASE_LOW);
			// Index match, qualified by device for device slots
			assign sel = (index_reg == crm_pkg::REG_INDEX[gi])
				& ((crm_pkg::REG_LD[gi] == crm_pkg::LD_GLOBAL) ? idx_global
				: (!idx_global & (logical_device_select
				== crm_pkg::REG_LD[gi])));
			// Reset load value: strap for the base low slot
			assign load = rst_low ? strap_val
				: crm_pkg::REG_RST[gi];

			// Storage cell with the reset class of this slot
			crm_cfg_cell #(
				.RST_VAL (crm_pkg::REG_RST[gi]),
				.CLS     (crm_pkg::REG_CLS[gi])
			) u_cell (
				.ref_clk  (ref_clk),
				.nrst     (nrst),
				.bus_rst  (bus_rst),
				.main_por (main_por),
				.stby_por (stby_por),
				.soft_rst (soft_reg),
				.ext_load (rst_low & strap_load),
				.load_val (load),
				.wr_en    (wr_data & sel),
				.wdata    (io_wdata),
				.q        (reg_q[gi])
			);

			// Read contribution of this slot
			// Every stored byte is also shown to the logical devices
			assign rd_chain[gi+1] = rd_chain[gi] | (sel ? reg_q[gi] : 8'h00);
			assign cfg_regs[gi*8 +: 8] = reg_q[gi];
		end
	endgenerate

	// Empty start of the read OR chain
	assign rd_chain[0] = 8'h00;

	// Current logical device, written through index 07h
	// Cleared by soft reset as well as by every hardware reset
	assign logical_device_select = reg_q[0];

	// Hard wired bytes; chip control and reserved read zero
	// Unmapped global indices fall through to zero as well
	assign fixed_rd =
		(index_reg == crm_pkg::IDX_PART_ID) ? PART_ID
		: (index_reg == crm_pkg::IDX_SI_REV) ? SILICON_REV
		: 8'h00;
	// Stored and hard wired bytes never share an index
	assign rd_mux = rd_chain[crm_pkg::NUM_REGS] | fixed_rd;

	// Read answer on the cycle after an accepted read
	// The byte stays until the next accepted read,
	// while the strobe lasts a single cycle
	assign rdata_next = rd_data ? rd_mux
		: (rd_index ? index_reg : rdata_reg);
	assign rvalid_next = rd_data | rd_index;

	// Read answer flops
	// Power-up leaves no answer pending
	// Refused reads never raise the strobe
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Outputs
	// Mode and pulse outputs come straight from flops
	// The block flag comes from the down counter
	assign io_rdata       = rdata_reg;
	assign io_rvalid      = rvalid_reg;
	assign cfg_mode       = (state_reg == ST_CONFIG);
	assign host_blocked   = blocked;
	assign soft_rst_pulse = soft_reg;

endmodule
`default_nettype wire

// File: bench/crm_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host master issuing configuration port cycles
module crm_host_model (
	input  wire logic        ref_clk,
	output logic      [15:0] io_addr,
	output logic      [7:0]  io_wdata,
	output logic             io_wr,
	output logic             io_rd,
	input  wire logic [7:0]  io_rdata,
	input  wire logic        io_rvalid
);
	// Idle bus, strobes low
	initial
	begin
		io_addr  = 16'hFFFF;
		io_wdata = 8'hFF;
		io_wr    = 1'b0;
		io_rd    = 1'b0;
	end
	// One write, held up to its taking edge; index first
	// Keys go to the base address
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		io_addr  <= a;
		io_wdata <= d;
		io_wr    <= 1'b1;
		@(posedge ref_clk);
		io_wr    <= 1'b0;
		io_addr  <= ~a;
		io_wdata <= ~d;
	endtask
	// One read; the answer stands in the cycle after the taking edge
	task automatic rd(input logic [15:0] a, output logic ok,
		output logic [7:0] d);
		@(posedge ref_clk);
		io_addr <= a;
		io_rd   <= 1'b1;
		@(posedge ref_clk);
		io_rd   <= 1'b0;
		io_addr <= ~a;
		@(negedge ref_clk);
		ok = io_rvalid;
		d  = io_rdata;
	endtask
endmodule
`default_nettype wire

// File: bench/crm_config_map_chk.sv
`timescale 1ns/1ns
`default_nettype none
// Watches host port, access block and reset loads
module crm_config_map_chk #(
	parameter int POR_BLOCK_CYC = 20
) (
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic        bus_rst,
	input wire logic        main_por,
	input wire logic        stby_por,
	input wire logic        strap_pin,
	input wire logic [15:0] io_addr,
	input wire logic [7:0]  io_wdata,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [7:0]  io_rdata,
	input wire logic        io_rvalid,
	input wire logic        cfg_mode,
	input wire logic        host_blocked,
	input wire logic        soft_rst_pulse,
	input wire logic [7:0]  logical_device_select,
	input wire logic [15:0] config_port_base,
	input wire logic [crm_pkg::NUM_REGS*8-1:0] cfg_regs
);
	// Host cycle may land: no block, no reset event
	wire logic        open_w = !host_blocked && !bus_rst && !main_por
		&& !stby_por;
	wire logic        at_idx = io_addr == config_port_base;
	wire logic        at_dat = io_addr == config_port_base + 16'h0001;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_read_answer: assert property (io_rd && open_w && cfg_mode
		&& (at_idx || at_dat) |=> io_rvalid) else $error("read lost");
	a_run_silent: assert property (io_rd && !cfg_mode
		|=> !io_rvalid) else $error("answer in run mode");
	a_key_enter: assert property (io_wr && open_w && !cfg_mode && at_idx
		&& io_wdata == crm_pkg::KEY_ENTER |=> cfg_mode) else $error("no entry");
	a_key_exit: assert property (io_wr && open_w && cfg_mode && at_idx
		&& io_wdata == crm_pkg::KEY_EXIT |=> !cfg_mode) else $error("no exit");
	a_por_block: assert property (main_por |=> host_blocked [*8])
		else $error("block too short");
	a_block_run: assert property (host_blocked |-> !cfg_mode)
		else $error("config mode while blocked");
	a_soft_once: assert property (soft_rst_pulse |=> !soft_rst_pulse)
		else $error("soft reset stuck");
	a_soft_load: assert property (soft_rst_pulse |=>
		logical_device_select == 8'h00 && cfg_regs[15*8+:8] == 8'h06
		&& cfg_regs[16*8+:8] == 8'h02) else $error("soft defaults missing");
	a_soft_keep: assert property (soft_rst_pulse
		|=> $stable(cfg_regs[27*8+:8])) else $error("mode lost on soft reset");
	a_hw_base: assert property (bus_rst || main_por |=> !cfg_mode
		&& config_port_base == {8'h00, strap_pin ? crm_pkg::BASE_LOW_STRAP1
		: crm_pkg::BASE_LOW_STRAP0}) else $error("base not strapped");
	a_stby_keep: assert property (stby_por && !bus_rst && !main_por
		|=> $stable(config_port_base)) else $error("base lost on standby");
	int blk_cnt;	// Block cycles since the last main power-on
	// Counts sampled block cycles
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			blk_cnt <= 0;
		else if (main_por)
			blk_cnt <= 0;
		else if (host_blocked)
			blk_cnt <= blk_cnt + 1;
	end
	a_block_len: assert property ($fell(host_blocked)
		|-> blk_cnt == POR_BLOCK_CYC) else $error("block length wrong");
endmodule
bind crm_config_map crm_config_map_chk #(.POR_BLOCK_CYC(POR_BLOCK_CYC)) u_chk (
	.ref_clk(ref_clk), .nrst(nrst), .bus_rst(bus_rst), .main_por(main_por),
	.stby_por(stby_por), .strap_pin(strap_pin), .io_addr(io_addr),
	.io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
	.io_rvalid(io_rvalid), .cfg_mode(cfg_mode), .host_blocked(host_blocked),
	.soft_rst_pulse(soft_rst_pulse),
	.logical_device_select(logical_device_select),
	.config_port_base(config_port_base), .cfg_regs(cfg_regs));
`default_nettype wire

// File: bench/test_config_register_map.sv
`timescale 1ns/1ns
`default_nettype none
module test_config_register_map;
	localparam logic [7:0] ID_VAL = 8'h5A;	// Arbitrary value
	localparam logic [7:0] RV_VAL = 8'h02;	// Arbitrary value
	logic              ref_clk, nrst, bus_rst, main_por, stby_por, strap_pin;
	wire logic [15:0]  io_addr, config_port_base;
	wire logic [7:0]   io_wdata, io_rdata, logical_device_select;
	wire logic         io_wr, io_rd, io_rvalid, cfg_mode, host_blocked;
	wire logic         soft_rst_pulse;	// Soft reset pulse to the devices
	logic      [15:0]  base;	// Where the host thinks the ports sit
	int                error_cnt, checked;
	crm_config_map #(.PART_ID(ID_VAL), .SILICON_REV(RV_VAL),
		.POR_BLOCK_CYC(20)) u_crm_config_map (.ref_clk(ref_clk), .nrst(nrst),
		.bus_rst(bus_rst), .main_por(main_por), .stby_por(stby_por),
		.strap_pin(strap_pin), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
		.io_rvalid(io_rvalid), .cfg_mode(cfg_mode),
		.host_blocked(host_blocked), .soft_rst_pulse(soft_rst_pulse),
		.logical_device_select(logical_device_select),
		.config_port_base(config_port_base), .cfg_regs());
	crm_host_model u_crm_host_model (.ref_clk(ref_clk), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
		.io_rdata(io_rdata), .io_rvalid(io_rvalid));
	// Free running clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Compare and count
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Index write, then data write
	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
		u_crm_host_model.wr(base, idx);
		u_crm_host_model.wr(base + 16'h0001, val);
	endtask
	task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
		logic ok;
		u_crm_host_model.wr(base, idx);
		u_crm_host_model.rd(base + 16'h0001, ok, d);
		check("answer", {15'h0000, ok}, 16'h0001);
	endtask
	// One-cycle reset event: {bus, main, standby}
	task automatic pulse(input logic [2:0] m);
		@(posedge ref_clk);
		{bus_rst, main_por, stby_por} <= m;
		@(posedge ref_clk);
		{bus_rst, main_por, stby_por} <= 3'h0;
		@(negedge ref_clk);
	endtask
	// Run mode silence, key entry, fixed and reserved bytes
	task automatic t_global;
		logic       ok;
		logic [7:0] d;
		u_crm_host_model.rd(base, ok, d);
		check("run read", {15'h0000, ok}, 16'h0000);
		u_crm_host_model.wr(base, crm_pkg::KEY_ENTER);
		@(negedge ref_clk);
		check("cfg_mode", {15'h0000, cfg_mode}, 16'h0001);
		reg_wr(crm_pkg::IDX_PART_ID, 8'h00);
		reg_rd(crm_pkg::IDX_PART_ID, d);
		check("part id", {8'h00, d}, {8'h00, ID_VAL});
		reg_wr(crm_pkg::IDX_SI_REV, 8'h00);
		reg_rd(crm_pkg::IDX_SI_REV, d);
		check("revision", {8'h00, d}, {8'h00, RV_VAL});
		reg_wr(crm_pkg::IDX_RSVD_A, 8'hFF);
		reg_rd(crm_pkg::IDX_RSVD_A, d);
		check("reserved", {8'h00, d}, 16'h0000);
		u_crm_host_model.rd(base, ok, d);
		check("index answer", {15'h0000, ok}, 16'h0001);
		check("index read", {8'h00, d}, {8'h00, crm_pkg::IDX_RSVD_A});
	endtask
	// Device select and per-device access
	task automatic t_device;
		logic [7:0] d;
		reg_wr(crm_pkg::IDX_LDN, 8'h03);
		@(negedge ref_clk);
		check("ldn", {8'h00, logical_device_select}, 16'h0003);
		reg_rd(8'hF0, d);
		check("printer mode", {8'h00, d}, 16'h003C);
		reg_wr(8'hF0, 8'h11);
		reg_rd(8'hF0, d);
		check("printer mode wr", {8'h00, d}, 16'h0011);
		reg_wr(crm_pkg::IDX_LDN, 8'h00);
		reg_wr(8'h70, 8'h0A);
		reg_rd(8'h70, d);
		check("floppy irq wr", {8'h00, d}, 16'h000A);
	endtask
	// Soft reset reloads some, keeps others
	task automatic t_soft;
		logic [7:0] d;
		reg_wr(crm_pkg::IDX_LDN, 8'h03);
		reg_wr(crm_pkg::IDX_CHIP_CTRL, 8'h01);
		@(negedge ref_clk);
		check("soft pulse", {15'h0000, soft_rst_pulse}, 16'h0001);
		@(negedge ref_clk);
		check("soft clear", {15'h0000, soft_rst_pulse}, 16'h0000);
		reg_rd(crm_pkg::IDX_CHIP_CTRL, d);
		check("chip ctrl", {8'h00, d}, 16'h0000);
		check("ldn soft", {8'h00, logical_device_select}, 16'h0000);
		reg_rd(8'h70, d);
		check("floppy irq", {8'h00, d}, 16'h0006);
		reg_wr(crm_pkg::IDX_LDN, 8'h03);
		reg_rd(8'hF0, d);
		check("printer kept", {8'h00, d}, 16'h0011);
		reg_rd(8'h74, d);
		check("printer dma", {8'h00, d}, 16'h0004);
	endtask
	// Port relocation, standby keeps it, bus reset restores it
	task automatic t_base;
		logic [7:0] d;
		reg_wr(crm_pkg::IDX_BASE_LOW, 8'h60);
		base = 16'h0060;
		reg_wr(crm_pkg::IDX_BASE_HIGH, 8'h01);
		base = 16'h0160;
		reg_rd(crm_pkg::IDX_BASE_HIGH, d);
		check("base high", {8'h00, d}, 16'h0001);
		pulse(3'h1);
		check("stby base", config_port_base, 16'h0160);
		pulse(3'h4);
		base = 16'h002E;
		check("bus base", config_port_base, base);
	endtask
	// Main power-on: strap 1, refused keys, exit key
	task automatic t_por;
		int i;
		@(posedge ref_clk);
		strap_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		pulse(3'h2);
		base = 16'h004E;
		check("por base", config_port_base, base);
		u_crm_host_model.wr(base, crm_pkg::KEY_ENTER);
		@(negedge ref_clk);
		check("blocked key", {15'h0000, cfg_mode}, 16'h0000);
		for (i = 0; i < 100 && host_blocked !== 1'b0; i++)
			@(negedge ref_clk);
		if (i == 100)
		begin
			error_cnt++;
			report_and_stop();
		end
		u_crm_host_model.wr(base, crm_pkg::KEY_ENTER);
		u_crm_host_model.wr(base, crm_pkg::KEY_EXIT);
		@(negedge ref_clk);
		check("exit key", {15'h0000, cfg_mode}, 16'h0000);
	endtask
	// Reset, then the scenarios in turn
	initial
	begin
		{nrst, bus_rst, main_por, stby_por, strap_pin} = 5'h00;
		base = 16'h002E;
		error_cnt = 0;
		checked = 0;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_global();
		t_device();
		t_soft();
		t_base();
		t_por();
		report_and_stop();
	end
endmodule
`default_nettype wire
